// ==== hw/rid_datapath.sv ====
// rotate instruction datapath with its file, working register and flags
// What this block does
// - rotate left no carry: shift left one, old bit 7 into bit 0
// - rotate right through carry: bit 0 to carry, old carry to bit 7
// - destination bit 0 writes working register, 1 writes file register
// - access bit 0 uses access bank, 1 uses bank select register
// - access 0, extended set on, f up to 5Fh: indexed literal offset
// - one cycle of four phases: decode, read, process, write
`include "rid_map.svh"
`timescale 1ns/1ps
`default_nettype none

module rid_datapath
    import rid_pkg::*;
#(
    parameter int FILE_BYTES = 512
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             busy,
    output logic             carry_flag,
    output logic             zero_flag,
    output logic             negative_flag
);

    // file sizes above one bank use the low bank bits, the rest wrap
    localparam int AW = $clog2(FILE_BYTES);

    function automatic rid_reg_t reg_sel(input logic [11:0] a);
        case (a)
            `RID_OFF_CTRL:   reg_sel = RID_R_CTRL;
            `RID_OFF_BANK:   reg_sel = RID_R_BANK;
            `RID_OFF_WREG:   reg_sel = RID_R_WREG;
            `RID_OFF_STATUS: reg_sel = RID_R_STATUS;
            `RID_OFF_INDEX:  reg_sel = RID_R_INDEX;
            `RID_OFF_INSTR:  reg_sel = RID_R_INSTR;
            `RID_OFF_FADDR:  reg_sel = RID_R_FADDR;
            `RID_OFF_FDATA:  reg_sel = RID_R_FDATA;
            default:         reg_sel = RID_R_NONE;
        endcase
    endfunction : reg_sel

    function automatic logic [11:0] eff_addr(
        input logic [7:0]  f,
        input logic        a,
        input logic        ext,
        input logic [3:0]  bank,
        input logic [11:0] index
    );
        if (a) begin
            eff_addr = {bank, f};
        end else if (f <= `RID_ACCESS_LIM && ext) begin
            eff_addr = index + {4'h0, f};
        end else if (f <= `RID_ACCESS_LIM) begin
            eff_addr = {`RID_LOW_BANK, f};
        end else begin
            eff_addr = {`RID_SFR_BANK, f};
        end
    endfunction : eff_addr

    // bus side state
    logic                        pready_q;
    logic                        pready_d;
    logic                        pslverr_q;
    logic                        pslverr_d;
    logic [31:0]                 prdata_q;
    logic [31:0]                 prdata_d;
    rid_reg_t                    sel;
    logic                        acc;
    logic                        commit;
    logic                        wr;

    // sequencer state
    rid_state_t                  state_q;
    rid_state_t                  state_d;
    logic                        busy_q;
    logic                        busy_d;
    logic [10:0]                 instr_q;
    logic [10:0]                 instr_d;
    logic [AW-1:0]               ea_q;
    logic [AW-1:0]               ea_d;
    logic [7:0]                  opnd_q;
    logic [7:0]                  opnd_d;
    logic [7:0]                  res_q;
    logic [7:0]                  res_d;
    logic                        cout_q;
    logic                        cout_d;

    // architectural state
    logic [FILE_BYTES-1:0][7:0]  file_q;
    logic [FILE_BYTES-1:0][7:0]  file_d;
    logic [7:0]                  wreg_q;
    logic [7:0]                  wreg_d;
    logic [2:0]                  status_q;
    logic [2:0]                  status_d;
    logic                        ext_q;
    logic                        ext_d;
    logic [3:0]                  bank_q;
    logic [3:0]                  bank_d;
    logic [11:0]                 index_q;
    logic [11:0]                 index_d;
    logic [11:0]                 faddr_q;
    logic [11:0]                 faddr_d;
    logic [11:0]                 ea_full;

    assign sel    = reg_sel(paddr);
    assign acc    = psel & penable;
    assign commit = acc & pready_q & ~pslverr_q;
    assign wr     = commit & pwrite;

    // answer one cycle into the access phase so that pready is a flop
    always_comb begin
        pready_d  = acc & ~pready_q;
        pslverr_d = 1'b0;
        prdata_d  = 32'h0000_0000;
        if (pready_d) begin
            // writes during an instruction would race the write-back
            pslverr_d = (sel == RID_R_NONE) | (pwrite & busy_q);
            if (!pwrite) begin
                case (sel)
                    RID_R_CTRL: begin
                        prdata_d[`RID_CTRL_EXT] = ext_q;
                    end
                    RID_R_BANK: begin
                        prdata_d[3:0] = bank_q;
                    end
                    RID_R_WREG: begin
                        prdata_d[7:0] = wreg_q;
                    end
                    RID_R_STATUS: begin
                        prdata_d[2:0] = status_q;
                    end
                    RID_R_INDEX: begin
                        prdata_d[11:0] = index_q;
                    end
                    RID_R_INSTR: begin
                        prdata_d[10:0] = instr_q;
                        prdata_d[`RID_BUSY_BIT] = busy_q;
                    end
                    RID_R_FADDR: begin
                        prdata_d[11:0] = faddr_q;
                    end
                    RID_R_FDATA: begin
                        prdata_d[7:0] = file_q[faddr_q[AW-1:0]];
                    end
                    default: begin
                        prdata_d = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
        end
    end

    assign ea_full = eff_addr(instr_q[`RID_IN_F_MSB:0],
                              instr_q[`RID_IN_A], ext_q,
                              bank_q, index_q);

    always_comb begin
        state_d = state_q;
        instr_d = instr_q;
        ea_d    = ea_q;
        opnd_d  = opnd_q;
        res_d   = res_q;
        cout_d  = cout_q;
        case (state_q)
            RID_IDLE: begin
                if (wr && sel == RID_R_INSTR) begin
                    instr_d = pwdata[10:0];
                    state_d = RID_Q1;
                end
            end
            RID_Q1: begin
                ea_d    = ea_full[AW-1:0];
                state_d = RID_Q2;
            end
            RID_Q2: begin
                opnd_d  = file_q[ea_q];
                state_d = RID_Q3;
            end
            RID_Q3: begin
                if (instr_q[`RID_IN_OP]) begin
                    res_d  = {status_q[`RID_ST_C], opnd_q[7:1]};
                    cout_d = opnd_q[0];
                end else begin
                    res_d  = {opnd_q[6:0], opnd_q[7]};
                    cout_d = status_q[`RID_ST_C];
                end
                state_d = RID_Q4;
            end
            RID_Q4: begin
                state_d = RID_IDLE;
            end
            default: begin
                state_d = RID_IDLE;
            end
        endcase
        busy_d = (state_d != RID_IDLE);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= RID_IDLE;
            busy_q  <= 1'b0;
            instr_q <= `RID_RST_INSTR;
            ea_q    <= '0;
            opnd_q  <= 8'h00;
            res_q   <= 8'h00;
            cout_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            busy_q  <= busy_d;
            instr_q <= instr_d;
            ea_q    <= ea_d;
            opnd_q  <= opnd_d;
            res_q   <= res_d;
            cout_q  <= cout_d;
        end
    end

    always_comb begin
        file_d   = file_q;
        wreg_d   = wreg_q;
        status_d = status_q;
        ext_d    = ext_q;
        bank_d   = bank_q;
        index_d  = index_q;
        faddr_d  = faddr_q;
        if (wr) begin
            case (sel)
                RID_R_CTRL: begin
                    ext_d = pwdata[`RID_CTRL_EXT];
                end
                RID_R_BANK: begin
                    bank_d = pwdata[3:0];
                end
                RID_R_WREG: begin
                    wreg_d = pwdata[7:0];
                end
                RID_R_STATUS: begin
                    status_d = pwdata[2:0];
                end
                RID_R_INDEX: begin
                    index_d = pwdata[11:0];
                end
                RID_R_FADDR: begin
                    faddr_d = pwdata[11:0];
                end
                RID_R_FDATA: begin
                    file_d[faddr_q[AW-1:0]] = pwdata[7:0];
                end
                default: begin
                    faddr_d = faddr_q;
                end
            endcase
        end
        // bus writes are refused while busy, so no merge is needed here
        if (state_q == RID_Q4) begin
            if (instr_q[`RID_IN_D]) begin
                file_d[ea_q] = res_q;
            end else begin
                wreg_d = res_q;
            end
            status_d[`RID_ST_N] = res_q[7];
            status_d[`RID_ST_Z] = (res_q == 8'h00);
            status_d[`RID_ST_C] = cout_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            file_q   <= '0;
            wreg_q   <= `RID_RST_W;
            status_q <= `RID_RST_STATUS;
            ext_q    <= `RID_RST_CTRL;
            bank_q   <= `RID_RST_BANK;
            index_q  <= `RID_RST_INDEX;
            faddr_q  <= `RID_RST_FADDR;
        end else begin
            file_q   <= file_d;
            wreg_q   <= wreg_d;
            status_q <= status_d;
            ext_q    <= ext_d;
            bank_q   <= bank_d;
            index_q  <= index_d;
            faddr_q  <= faddr_d;
        end
    end

    assign prdata        = prdata_q;
    assign pready        = pready_q;
    assign pslverr       = pslverr_q;
    assign busy          = busy_q;
    assign carry_flag    = status_q[`RID_ST_C];
    assign zero_flag     = status_q[`RID_ST_Z];
    assign negative_flag = status_q[`RID_ST_N];

endmodule : rid_datapath

`default_nettype wire

// ==== hw/rid_map.svh ====
// register offsets, field positions and reset values of the rotate datapath
`ifndef RID_MAP_SVH
`define RID_MAP_SVH

`define RID_OFF_CTRL    12'h000
`define RID_OFF_BANK    12'h004
`define RID_OFF_WREG    12'h008
`define RID_OFF_STATUS  12'h00c
`define RID_OFF_INDEX   12'h010
`define RID_OFF_INSTR   12'h014
`define RID_OFF_FADDR   12'h018
`define RID_OFF_FDATA   12'h01c

`define RID_CTRL_EXT    0
`define RID_ST_C        0
`define RID_ST_Z        1
`define RID_ST_N        2
`define RID_IN_F_MSB    7
`define RID_IN_A        8
`define RID_IN_D        9
`define RID_IN_OP       10
`define RID_BUSY_BIT    31

`define RID_RST_CTRL    1'h0
`define RID_RST_BANK    4'h0
`define RID_RST_W       8'h00
`define RID_RST_STATUS  3'h0
`define RID_RST_INDEX   12'h000
`define RID_RST_INSTR   11'h000
`define RID_RST_FADDR   12'h000

`define RID_ACCESS_LIM  8'h5f
`define RID_LOW_BANK    4'h0
`define RID_SFR_BANK    4'hf

`endif

// ==== hw/rid_pkg.sv ====
// types shared by the rotate datapath
package rid_pkg;

    typedef enum logic [2:0] {
        RID_IDLE,
        RID_Q1,
        RID_Q2,
        RID_Q3,
        RID_Q4
    } rid_state_t;

    typedef enum logic [3:0] {
        RID_R_CTRL,
        RID_R_BANK,
        RID_R_WREG,
        RID_R_STATUS,
        RID_R_INDEX,
        RID_R_INSTR,
        RID_R_FADDR,
        RID_R_FDATA,
        RID_R_NONE
    } rid_reg_t;

endpackage : rid_pkg

// ==== sim/rid_checker.sv ====
// port assertions for the rotate datapath
`include "rid_map.svh"
`timescale 1ns/1ps
`default_nettype none
module rid_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        busy,
    input wire logic        carry_flag,
    input wire logic        zero_flag,
    input wire logic        negative_flag
);
    logic acc, wst_d, wst_q, op_d, op_q;
    assign acc = psel && penable && pready && pwrite && !pslverr;
    always_comb begin
        wst_d = acc && paddr == `RID_OFF_STATUS;
        op_d  = (acc && paddr == `RID_OFF_INSTR) ? pwdata[`RID_IN_OP] : op_q;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wst_q <= 1'b0;
            op_q  <= 1'b0;
        end else begin
            wst_q <= wst_d;
            op_q  <= op_d;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_busy4; $rose(busy) |-> busy[*4] ##1 !busy; endproperty
    a_busy4: assert property (p_busy4)
        else $error("busy span is not four cycles");
    property p_start; acc && paddr == `RID_OFF_INSTR |-> ##[1:2] busy;
    endproperty
    a_start: assert property (p_start)
        else $error("instruction write did not start");
    property p_wait; psel && !penable |=> !pready ##1 pready; endproperty
    a_wait: assert property (p_wait)
        else $error("ready not on second access cycle");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse)
        else $error("ready longer than one cycle");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err)
        else $error("error without ready");
    property p_zn;
        $changed({zero_flag, negative_flag}) |-> $fell(busy) || wst_q;
    endproperty
    a_zn: assert property (p_zn)
        else $error("zero or negative changed without cause");
    // left rotate must leave carry alone, so only the right op may move it
    property p_cy; $changed(carry_flag) |-> ($fell(busy) && op_q) || wst_q;
    endproperty
    a_cy: assert property (p_cy)
        else $error("carry changed without cause");
    property p_negr;
        $fell(busy) && op_q |-> negative_flag == $past(carry_flag);
    endproperty
    a_negr: assert property (p_negr)
        else $error("old carry not in result top bit");
endmodule : rid_checker
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench for the rotate datapath
`include "rid_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, busy, carry_flag, zero_flag, negative_flag;
    int          failures = 0;
    int          n_compared = 0;
    // a file larger than one bank is needed for the bank select to be seen
    rid_datapath #(.FILE_BYTES(512)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .busy(busy), .carry_flag(carry_flag), .zero_flag(zero_flag),
        .negative_flag(negative_flag));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic fwr(input logic [7:0] f, input logic [7:0] v,
                       input logic [2:0] st);
        xfer(1'b1, `RID_OFF_FADDR, {24'h0, f});
        xfer(1'b1, `RID_OFF_FDATA, {24'h0, v});
        xfer(1'b1, `RID_OFF_STATUS, {29'h0, st});
    endtask : fwr
    task automatic frd(input logic [7:0] f);
        xfer(1'b1, `RID_OFF_FADDR, {24'h0, f});
        xfer(1'b0, `RID_OFF_FDATA, 32'h0);
    endtask : frd
    // a write while busy is issued on every run to prove it is refused
    task automatic run(input logic op, input logic d, input logic a,
                       input logic [7:0] f);
        int k;
        k = 0;
        xfer(1'b1, `RID_OFF_INSTR, {21'h0, op, d, a, f});
        xfer(1'b1, `RID_OFF_WREG, 32'h55);
        chk("busy_write_err", {31'h0, err}, 32'h1);
        do begin
            xfer(1'b0, `RID_OFF_INSTR, 32'h0);
            k++;
        end while (rd[31] && k < 9);
        chk("busy_done", {31'h0, rd[31]}, 32'h0);
    endtask : run
    function automatic logic [31:0] nzc();
        return {29'h0, negative_flag, zero_flag, carry_flag};
    endfunction : nzc
    task give_verdict;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            xfer(1'b0, 12'(i * 4), 32'h0);
            chk("reset_value", rd, 32'h0);
        end
        xfer(1'b0, 12'h020, 32'h0);
        chk("unmapped_err", {31'h0, err}, 32'h1);
        fwr(8'h20, 8'hab, 3'h1);
        run(1'b0, 1'b1, 1'b1, 8'h20);
        frd(8'h20);
        chk("rl_file", rd, 32'h57);
        chk("rl_flags", nzc(), 32'h1);
        fwr(8'h21, 8'he6, 3'h0);
        run(1'b1, 1'b0, 1'b1, 8'h21);
        xfer(1'b0, `RID_OFF_WREG, 32'h0);
        chk("rr_wreg", rd, 32'h73);
        frd(8'h21);
        chk("rr_file_kept", rd, 32'he6);
        chk("rr_flags", nzc(), 32'h0);
        fwr(8'h22, 8'h01, 3'h1);
        run(1'b1, 1'b1, 1'b1, 8'h22);
        frd(8'h22);
        chk("rr_carry_in", rd, 32'h80);
        chk("rr_carry_flags", nzc(), 32'h5);
        fwr(8'h23, 8'h00, 3'h0);
        run(1'b0, 1'b1, 1'b1, 8'h23);
        chk("zero_flags", nzc(), 32'h2);
        fwr(8'h10, 8'h02, 3'h0);
        xfer(1'b1, `RID_OFF_BANK, 32'h1);
        run(1'b0, 1'b1, 1'b0, 8'h10);
        frd(8'h10);
        chk("access_bank", rd, 32'h04);
        xfer(1'b1, `RID_OFF_FADDR, 32'h110);
        xfer(1'b1, `RID_OFF_FDATA, 32'h03);
        run(1'b0, 1'b1, 1'b1, 8'h10);
        xfer(1'b0, `RID_OFF_FDATA, 32'h0);
        chk("bank_select", rd, 32'h06);
        frd(8'h10);
        chk("bank_other", rd, 32'h04);
        xfer(1'b1, `RID_OFF_CTRL, 32'h1);
        xfer(1'b1, `RID_OFF_INDEX, 32'h40);
        fwr(8'h50, 8'h81, 3'h0);
        run(1'b0, 1'b1, 1'b0, 8'h10);
        frd(8'h50);
        chk("indexed", rd, 32'h03);
        frd(8'h10);
        chk("indexed_other", rd, 32'h04);
        xfer(1'b1, `RID_OFF_FADDR, 32'h160);
        xfer(1'b1, `RID_OFF_FDATA, 32'h40);
        run(1'b0, 1'b1, 1'b0, 8'h60);
        xfer(1'b0, `RID_OFF_FDATA, 32'h0);
        chk("above_limit", rd, 32'h80);
        give_verdict;
    end
    initial begin
        repeat (5000) @(posedge pclk);
        failures++;
        give_verdict;
    end
endmodule : tb_top
bind rid_datapath rid_checker chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .busy(busy),
    .carry_flag(carry_flag), .zero_flag(zero_flag),
    .negative_flag(negative_flag));
`default_nettype wire
